/* File: rtl/fdc_regs.vh */
// register map and field constants for the fec decoder control bank
// assumes word-per-register apb with byte address = 4 * index
`ifndef FDC_REGS_VH
`define FDC_REGS_VH
// register indexes (byte address is four times these)
`define FDC_IDX_DEMAP 7'h00
`define FDC_IDX_DESCR 7'h41
`define FDC_IDX_IRD 7'h43
`define FDC_IDX_JRD 7'h44
`define FDC_IDX_MEMMODE 7'h45
`define FDC_IDX_OVRCTL 7'h46
`define FDC_IDX_IOVR 7'h47
`define FDC_IDX_JOVR 7'h48
`define FDC_IDX_PTRH 7'h49
`define FDC_IDX_PTRL 7'h4a
`define FDC_IDX_LOCK 7'h4b
`define FDC_IDX_LOSS 7'h4c
`define FDC_IDX_PATT 7'h4d
`define FDC_IDX_CKERR 7'h4e
`define FDC_IDX_IRQST 7'h78
`define FDC_IDX_IRQMSK 7'h79
// reset values
`define FDC_RST_DEMAP 8'h03
`define FDC_RST_PATT 8'h47
`define FDC_RST_LOCK 8'h04
`define FDC_RST_LOSS 8'h04
// fixed 128 x 1 geometry
`define FDC_FIX_I 8'h80
`define FDC_FIX_J 7'h01
// on-chip buffer depth, 8 kbytes
`define FDC_INT_BYTES 14'h2000
// interrupt status bits
`define FDC_IRQ_LOCK 0
`define FDC_IRQ_LOSS 1
`define FDC_IRQ_CKERR 2
`endif

/* File: rtl/fdc_ctrl.v */
// fec decoder control register bank with interleave pointer and sync fsm
// assumes an apb master on pclk; datapath inputs synchronous to pclk
`timescale 1ns/10ps
`include "fdc_regs.vh"
module fdc_ctrl (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // decoder datapath
    input wire [6:0] descr_data,
    input wire byte_valid,
    input wire [7:0] rx_byte,
    input wire frame_start,
    input wire checksum_bad,
    input wire [7:0] sync_ctrl_i,
    input wire [6:0] sync_ctrl_j,
    input wire [7:0] annex_i,
    input wire [6:0] annex_j,
    // outputs to decoder chain and sram
    output reg demapper_standard_select,
    output reg [7:0] geom_i,
    output reg [6:0] geom_j,
    output reg use_external,
    output reg [15:0] sram_addr,
    output reg sram_we,
    output reg data_enable,
    output reg data_error,
    output reg irq
);
    // software-visible control fields
    reg [7:0] demap;
    reg internal_buffer_bypass;
    reg variable_depth_interleave;
    reg interleave_override_enable;
    reg [7:0] i_ovr;
    reg [6:0] j_ovr;
    reg [7:0] lock_cnt;
    reg [7:0] loss_cnt;
    reg [7:0] frame_sync_pattern;
    reg checksum_error_flag_enable;
    // interrupt status and mask
    reg [2:0] irq_stat;
    reg [2:0] irq_mask;
    // datapath bookkeeping
    reg [13:0] int_fill;
    reg [1:0] state;
    reg [7:0] hits;
    reg [7:0] misses;
    reg [2:0] ev;
    // combinational next values
    reg [31:0] next_rdata;
    reg [7:0] next_i;
    reg [6:0] next_j;
    // bus decode
    wire acc;
    wire wr;
    wire [6:0] idx;
    wire idx_ok;
    wire is_sync;
    // frame sync states
    localparam ST_IDLE = 2'd0;
    localparam ST_SEEK = 2'd1;
    localparam ST_LOCK = 2'd2;

    assign acc = psel & penable & pready;
    assign wr = acc & pwrite;
    assign idx = paddr[8:2];
    // only aligned words inside the bank decode
    assign idx_ok = (paddr[31:9] == 23'h000000) & (paddr[1:0] == 2'b00);
    assign is_sync = byte_valid & frame_start & (rx_byte == frame_sync_pattern);

    // zero-wait slave: ready asserted in the access phase
    // pready drops after one cycle, so every transfer takes two
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pready <= 1'b0;
        else
            pready <= psel & ~penable;
    end

    // read mux over the seven sub-groups; unused bits read zero
    always @*
    begin
        next_rdata = 32'h00000000;
        case (idx)
            `FDC_IDX_DEMAP: next_rdata[7:0] = demap;
            `FDC_IDX_DESCR: next_rdata[6:0] = descr_data;
            `FDC_IDX_IRD: next_rdata[7:0] = geom_i;
            `FDC_IDX_JRD: next_rdata[6:0] = geom_j;
            `FDC_IDX_MEMMODE: next_rdata[1:0] =
                {internal_buffer_bypass, variable_depth_interleave};
            `FDC_IDX_OVRCTL: next_rdata[0] = interleave_override_enable;
            `FDC_IDX_IOVR: next_rdata[7:0] = i_ovr;
            `FDC_IDX_JOVR: next_rdata[6:0] = j_ovr;
            `FDC_IDX_PTRH: next_rdata[7:0] = sram_addr[15:8];
            `FDC_IDX_PTRL: next_rdata[7:0] = sram_addr[7:0];
            `FDC_IDX_LOCK: next_rdata[7:0] = lock_cnt;
            `FDC_IDX_LOSS: next_rdata[7:0] = loss_cnt;
            `FDC_IDX_PATT: next_rdata[7:0] = frame_sync_pattern;
            `FDC_IDX_CKERR: next_rdata[0] = checksum_error_flag_enable;
            `FDC_IDX_IRQST: next_rdata[2:0] = irq_stat;
            `FDC_IDX_IRQMSK: next_rdata[2:0] = irq_mask;
            default: next_rdata = 32'h00000000;
        endcase
    end

    // read data and error registered during setup, valid in access phase
    // out-of-range or misaligned accesses get pslverr; holes read zero
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (psel & ~penable)
        begin
            prdata <= idx_ok ? next_rdata : 32'h00000000;
            pslverr <= ~idx_ok;
        end
    end

    // writable registers; read-only and unmapped indexes drop writes
    // bits outside each field are dropped, so they read back as zero
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            demap <= `FDC_RST_DEMAP;
            internal_buffer_bypass <= 1'b0;
            variable_depth_interleave <= 1'b0;
            interleave_override_enable <= 1'b0;
            i_ovr <= `FDC_FIX_I;
            j_ovr <= `FDC_FIX_J;
            lock_cnt <= `FDC_RST_LOCK;
            loss_cnt <= `FDC_RST_LOSS;
            frame_sync_pattern <= `FDC_RST_PATT;
            checksum_error_flag_enable <= 1'b0;
            irq_mask <= 3'b000;
        end
        else if (wr & idx_ok)
        begin
            case (idx)
                `FDC_IDX_DEMAP: demap <= {pwdata[7], 5'b00000, pwdata[1:0]};
                `FDC_IDX_MEMMODE:
                begin
                    internal_buffer_bypass <= pwdata[1];
                    variable_depth_interleave <= pwdata[0];
                end
                `FDC_IDX_OVRCTL: interleave_override_enable <= pwdata[0];
                `FDC_IDX_IOVR: i_ovr <= pwdata[7:0];
                `FDC_IDX_JOVR: j_ovr <= pwdata[6:0];
                `FDC_IDX_LOCK: lock_cnt <= pwdata[7:0];
                `FDC_IDX_LOSS: loss_cnt <= pwdata[7:0];
                `FDC_IDX_PATT: frame_sync_pattern <= pwdata[7:0];
                `FDC_IDX_CKERR: checksum_error_flag_enable <= pwdata[0];
                `FDC_IDX_IRQMSK: irq_mask <= pwdata[2:0];
                default: irq_mask <= irq_mask;
            endcase
        end
    end

    // geometry selection: override, then variable depth, then annex, then fixed
    // annex_i of zero means the chain offers no annex geometry
    always @*
    begin
        if (interleave_override_enable)
        begin
            next_i = i_ovr;
            next_j = j_ovr;
        end
        else if (variable_depth_interleave)
        begin
            next_i = sync_ctrl_i;
            next_j = sync_ctrl_j;
        end
        else if (annex_i != 8'h00)
        begin
            next_i = annex_i; // geometry from qam order and annex
            next_j = annex_j;
        end
        else
        begin
            next_i = `FDC_FIX_I;
            next_j = `FDC_FIX_J;
        end
    end

    // external pointer advances once the internal buffer is spent;
    // annex a 256qam cannot fit on-chip, so pointer wrap is left to sram
    // the fill count never drains, so only the first fill is modelled;
    // a real buffer frees room as bytes leave for the decoder
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_fill <= 14'h0000;
            sram_addr <= 16'h0000;
            sram_we <= 1'b0;
            use_external <= 1'b0;
            geom_i <= `FDC_FIX_I;
            geom_j <= `FDC_FIX_J;
            demapper_standard_select <= 1'b0;
        end
        else
        begin
            geom_i <= next_i;
            geom_j <= next_j;
            demapper_standard_select <= demap[7];
            use_external <= internal_buffer_bypass |
                (int_fill == `FDC_INT_BYTES);
            sram_we <= 1'b0;
            if (byte_valid)
            begin
                if (!internal_buffer_bypass && int_fill != `FDC_INT_BYTES)
                    int_fill <= int_fill + 14'h0001;
                else
                begin
                    sram_addr <= sram_addr + 16'h0001;
                    sram_we <= 1'b1;
                end
            end
        end
    end

    // frame sync state machine: seek hits, lock, lose after misses
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            hits <= 8'h00;
            misses <= 8'h00;
            data_enable <= 1'b0;
            data_error <= 1'b0;
            ev <= 3'b000;
        end
        else
        begin
            ev <= 3'b000;
            data_error <= byte_valid & data_enable &
                checksum_error_flag_enable & checksum_bad;
            ev[`FDC_IRQ_CKERR] <= byte_valid & data_enable &
                checksum_error_flag_enable & checksum_bad;
            case (state)
                // wait for a pattern byte at a frame position
                ST_IDLE:
                begin
                    data_enable <= 1'b0;
                    if (is_sync)
                    begin
                        hits <= 8'h01;
                        state <= ST_SEEK;
                    end
                end
                // lock is judged the cycle after the last hit
                ST_SEEK:
                begin
                    if (hits >= lock_cnt)
                    begin
                        state <= ST_LOCK;
                        data_enable <= 1'b1;
                        misses <= 8'h00;
                        ev[`FDC_IRQ_LOCK] <= 1'b1;
                    end
                    else if (is_sync)
                        hits <= hits + 8'h01;
                    // a wrong byte at a frame position restarts the search
                    else if (byte_valid & frame_start)
                        state <= ST_IDLE;
                end
                // only consecutive misses count; a good sync clears them
                // a loss count of zero behaves as one
                ST_LOCK:
                begin
                    if (is_sync)
                        misses <= 8'h00;
                    else if (byte_valid & frame_start)
                    begin
                        if (misses + 8'h01 >= loss_cnt)
                        begin
                            state <= ST_IDLE;
                            data_enable <= 1'b0;
                            ev[`FDC_IRQ_LOSS] <= 1'b1;
                        end
                        misses <= misses + 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // sticky status, write one to clear; a new event wins over the clear
    // status reads see an event one cycle after it happens
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_stat <= 3'b000;
            irq <= 1'b0;
        end
        else
        begin
            if (wr & idx_ok & (idx == `FDC_IDX_IRQST))
                irq_stat <= (irq_stat & ~pwdata[2:0]) | ev;
            else
                irq_stat <= irq_stat | ev;
            // a mask bit of one silences that source; reset enables all
            irq <= |(irq_stat & ~irq_mask);
        end
    end
endmodule

/* File: sim/fdc_ctrl_asserts.sv */
// port assertions for the fec decoder control bank
// assumes a bind onto fdc_ctrl, one pclk domain
`timescale 1ns/10ps
module fdc_ctrl_asserts (
    // apb side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // datapath side
    input wire byte_valid,
    input wire checksum_bad,
    input wire [15:0] sram_addr,
    input wire sram_we,
    input wire data_error
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // apb answer is wait-free and one cycle wide
    property p_rdy; psel && !penable |=> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("ready late");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready long");
    property p_idle; !psel |=> !pready; endproperty
    a_idle: assert property (p_idle) else $error("stray ready");
    // read data may only move when a new transfer starts
    property p_hold; !(psel && !penable) |=> $stable(prdata); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved");
    property p_err0; pready && pslverr && !pwrite |-> prdata == 32'h0;
    endproperty
    a_err0: assert property (p_err0) else $error("error read");
    // spill writes follow a byte and step the pointer by one
    property p_we; sram_we |-> $past(byte_valid); endproperty
    a_we: assert property (p_we) else $error("stray write");
    property p_step;
        $changed(sram_addr) |-> sram_addr == $past(sram_addr) + 16'h1;
    endproperty
    a_step: assert property (p_step) else $error("ptr jump");
    property p_cke; data_error |-> $past(checksum_bad); endproperty
    a_cke: assert property (p_cke) else $error("stray error");
endmodule
bind fdc_ctrl fdc_ctrl_asserts chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr, .byte_valid, .checksum_bad,
    .sram_addr, .sram_we, .data_error);

/* File: sim/fdc_sram_model.sv */
// external sram on the de-interleaver spill path, counts writes
// assumes single-cycle write strobes on pclk
`timescale 1ns/10ps
module fdc_sram_model (
    // strobe side
    input wire pclk,
    input wire [15:0] sram_addr,
    input wire sram_we,
    // bench view
    output int wr_cnt
);
    logic [15:0] mem_hit [0:65535];
    initial wr_cnt = 0;
    // storage is always fitted, so a 256qam annex a setup has room
    always @(posedge pclk)
        if (sram_we)
        begin
            wr_cnt <= wr_cnt + 1;
            mem_hit[sram_addr] <= sram_addr;
        end
endmodule

/* File: sim/fec_decoder_control_regs_tb.sv */
// bench for the fec decoder control bank: apb tasks and byte stream
// assumes fdc_ctrl with the sram model, one 10 mhz pclk
`timescale 1ns/10ps
module fec_decoder_control_regs_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
    logic byte_valid, frame_start, checksum_bad, sram_we, irq, err_seen;
    logic demapper_standard_select, use_external, data_enable, data_error;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [7:0] rx_byte, geom_i;
    logic [6:0] geom_j;
    logic [15:0] sram_addr;
    int error_cnt, samples_checked, wr_cnt, w0;
    // upstream inputs: descr and sync control held steady, annex set by the test
    wire [6:0] descr_data = 7'h55;
    wire [7:0] sync_ctrl_i = 8'h11;
    wire [6:0] sync_ctrl_j = 7'h05;
    logic [7:0] annex_i;
    logic [6:0] annex_j;
    fdc_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .descr_data, .byte_valid,
        .rx_byte, .frame_start, .checksum_bad, .sync_ctrl_i, .sync_ctrl_j,
        .annex_i, .annex_j, .demapper_standard_select, .geom_i, .geom_j,
        .use_external, .sram_addr, .sram_we, .data_enable, .data_error,
        .irq);
    fdc_sram_model ram (.pclk, .sram_addr, .sram_we, .wr_cnt);
    // 100 ns clock
    initial
    begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    // error flag is a one-cycle pulse, so latch it
    always @(posedge pclk)
        if (data_error)
            err_seen <= 1;
    task summarize;
        $display("checked %0d failed %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp, input string s);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", s, exp, seen);
        end
    endtask
    // one apb transfer, held until pready is sampled
    task apb(input w, input [31:0] a, input [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        rd = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 40)
        begin
            error_cnt++;
            summarize;
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        apb(1, a, d);
    endtask
    task rdc(input [31:0] a, input [31:0] e, input string s);
        apb(0, a, 0);
        chk(rd, e, s);
    endtask
    task bytes(input int n, input [7:0] b, input fs, input ck);
        repeat (n)
        begin
            @(posedge pclk);
            byte_valid <= 1;
            rx_byte <= b;
            frame_start <= fs;
            checksum_bad <= ck;
        end
        @(posedge pclk);
        byte_valid <= 0;
        frame_start <= 0;
        // let status and pointers settle before the next read
        repeat (3) @(posedge pclk);
    endtask
    task rst;
        presetn <= 0;
        repeat (4) @(posedge pclk);
        presetn <= 1;
    endtask
    initial
    begin
        {presetn, psel, penable, pwrite, byte_valid, frame_start} = 0;
        {checksum_bad, err_seen, paddr, pwdata, rx_byte} = 0;
        {annex_i, annex_j} = 0;
        rst;
        // reset values, field masks and refusals
        rdc(32'h000, 32'h03, "demap");
        rdc(32'h134, 32'h47, "pattern");
        chk({geom_i, 1'b0, geom_j}, 16'h8001, "fixed");
        wr(32'h000, 32'hff);
        rdc(32'h000, 32'h83, "demap");
        chk(demapper_standard_select, 1, "dvb");
        wr(32'h000, 32'h03);
        wr(32'h104, 32'hff);
        rdc(32'h104, 32'h55, "descr");
        apb(0, 32'h200, 0); // outside the bank
        chk({slv, rd}, 33'h100000000, "unmapped");
        chk(demapper_standard_select, 0, "davic");
        $display("register test done");
        // geometry: override, then variable depth, then fixed, then annex
        wr(32'h118, 32'hff);
        wr(32'h11c, 32'h2c);
        wr(32'h120, 32'hff);
        rdc(32'h110, 32'h7f, "j in use");
        rdc(32'h10c, 32'h2c, "i in use");
        chk({geom_i, 1'b0, geom_j}, 16'h2c7f, "override");
        wr(32'h118, 32'h00);
        wr(32'h114, 32'hff);
        rdc(32'h114, 32'h03, "memmode");
        chk({geom_i, 1'b0, geom_j}, 16'h1105, "variable");
        wr(32'h114, 32'h02);
        rdc(32'h118, 32'h00, "ovr");
        chk({geom_i, 1'b0, geom_j}, 16'h8001, "level one");
        annex_i <= 8'h0c;
        annex_j <= 7'h11;
        rdc(32'h10c, 32'h0c, "i annex");
        rdc(32'h110, 32'h11, "j annex");
        annex_i <= 8'h00;
        // bypass sends bytes straight to the sram
        w0 = wr_cnt;
        bytes(2, 8'h00, 0, 0);
        rdc(32'h128, 32'h02, "ptr lo");
        chk(use_external, 1, "bypass");
        chk(wr_cnt - w0, 2, "bypass writes");
        $display("geometry test done");
        // normal fill: on-chip buffer first, then spill
        rst;
        w0 = wr_cnt;
        bytes(8191, 8'h00, 0, 0);
        rdc(32'h128, 32'h00, "ptr lo");
        chk(use_external, 0, "internal");
        bytes(260, 8'h00, 0, 0);
        rdc(32'h124, 32'h01, "ptr hi");
        rdc(32'h128, 32'h03, "ptr lo");
        chk(wr_cnt - w0, 259, "spill writes");
        $display("memory test done");
        // frame sync lock, interrupt, checksum flag, loss
        wr(32'h12c, 32'h02);
        wr(32'h130, 32'h02);
        bytes(1, 8'h47, 1, 0);
        rdc(32'h1e0, 32'h00, "status");
        chk(data_enable, 0, "withheld");
        bytes(1, 8'h47, 1, 1);
        rdc(32'h1e0, 32'h01, "status");
        chk({data_enable, irq, err_seen}, 3'b110, "locked");
        wr(32'h1e4, 32'h01);
        rdc(32'h1e4, 32'h01, "mask");
        chk(irq, 0, "masked");
        wr(32'h1e4, 32'h00);
        wr(32'h1e0, 32'h01);
        rdc(32'h1e0, 32'h00, "cleared");
        wr(32'h138, 32'h01);
        bytes(1, 8'h47, 1, 1);
        rdc(32'h138, 32'h01, "ckerr");
        chk(err_seen, 1, "flagged");
        bytes(2, 8'h00, 1, 0);
        rdc(32'h1e0, 32'h06, "status");
        chk({data_enable, irq}, 2'b01, "lost");
        $display("sync test done");
        summarize;
    end
endmodule
